// File: can_irq_defs.svh
/*
 holds register offsets, field positions, reset values and fault-confinement steps
 assumes inclusion by bare name from the design files
*/
`ifndef CAN_IRQ_DEFS_SVH
`define CAN_IRQ_DEFS_SVH
`define OFS_MASK        8'h00
`define OFS_ERR_COUNTS  8'h04
`define OFS_STATUS      8'h08
`define OFS_IRQ_MASK    8'h0C
`define MASK_IMPL       16'h00EF
`define MASK_RESET      16'h0000
`define CNT_RESET       8'h00
`define BIT_TX_BUF      0
`define BIT_RX_BUF      1
`define BIT_RX_OVF      2
`define BIT_RX_AFULL    3
`define BIT_ERROR       5
`define BIT_WAKEUP      6
`define BIT_INVALID     7
`define STEP_TX_ERR     8'h08
`define STEP_RX_ERR     8'h01
`define STEP_RX_DOM     8'h08
`define RX_PASSIVE_MAX  8'h7F
`define RX_REWIND       8'h77
`endif

// File: can_irq_pkg.sv
/*
 holds the shared types of the interrupt mask and error counter block
 assumes nothing beyond a SystemVerilog compiler
*/
package can_irq_pkg;
  typedef enum logic [1:0] {
    ev_none,
    ev_tx_error,
    ev_rx_error,
    ev_rx_error_dominant
  } err_kind_t;
endpackage

// File: err_event_if.sv
/*
 holds the interface carrying protocol events from the top to the counter
 assumes one clock domain shared by both ends
*/
`timescale 1ns/1ps
`default_nettype none
interface err_event_if;
  can_irq_pkg::err_kind_t kind;
  logic                   tx_ok;
  logic                   rx_ok;
  logic [7:0]             tx_count;
  logic [7:0]             rx_count;
  modport source (output kind, output tx_ok, output rx_ok, input tx_count, input rx_count);
  modport counter (input kind, input tx_ok, input rx_ok, output tx_count, output rx_count);
endinterface
`default_nettype wire

// File: can_err_counter.sv
/*
 holds the transmit and receive error counters with saturation
 assumes one-cycle event pulses on the same clock, at most one kind per cycle
*/
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defs.svh"
module can_err_counter (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  err_event_if.counter ev
);
  logic [7:0] tx_count_reg;
  logic [7:0] rx_count_reg;

  // transmit count: +8 on error, -1 on good frame, clamps at 255 and 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_count_reg <= `CNT_RESET;
    end else if (ev.kind == can_irq_pkg::ev_tx_error) begin
      tx_count_reg <= (tx_count_reg > 8'hFF - `STEP_TX_ERR) ? 8'hFF
                      : tx_count_reg + `STEP_TX_ERR;
    end else if (ev.tx_ok && tx_count_reg != 8'h00) begin
      tx_count_reg <= tx_count_reg - 8'h01;
    end
  end

  // receive count: +1 or +8 on error, good frame steps down or rewinds from passive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_count_reg <= `CNT_RESET;
    end else if (ev.kind == can_irq_pkg::ev_rx_error) begin
      rx_count_reg <= (rx_count_reg == 8'hFF) ? 8'hFF : rx_count_reg + `STEP_RX_ERR;
    end else if (ev.kind == can_irq_pkg::ev_rx_error_dominant) begin
      rx_count_reg <= (rx_count_reg > 8'hFF - `STEP_RX_DOM) ? 8'hFF
                      : rx_count_reg + `STEP_RX_DOM;
    end else if (ev.rx_ok) begin
      if (rx_count_reg > `RX_PASSIVE_MAX) begin
        rx_count_reg <= `RX_REWIND;
      end else if (rx_count_reg != 8'h00) begin
        rx_count_reg <= rx_count_reg - 8'h01;
      end
    end
  end

  assign ev.tx_count = tx_count_reg;
  assign ev.rx_count = rx_count_reg;
endmodule
`default_nettype wire

// File: can_irq_error_count.sv
/*
 holds the CAN interrupt-enable mask, error count register and AHB-Lite slave
 assumes event inputs are one-cycle pulses from protocol logic on hclk
*/
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defs.svh"
// Function
// - 16-bit mask; bits 7,6,5,2,1,0 gate sources; 15-8 and 4 read zero.
// - receive almost-full request passes only while mask bit 3 is one.
// - transmit error count shown in error count bits 15 to 8.
// - receive error count shown in error count bits 7 to 0.
// - error count register read-only; both counts clear at reset.
module can_irq_error_count (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  src_req,
  input  wire logic [1:0]  err_kind,
  input  wire logic        tx_frame_ok,
  input  wire logic        rx_frame_ok,
  output logic      [7:0]  irq_req,
  output logic             irq
);
  err_event_if ev ();

  logic [15:0] can_interrupt_mask_reg;
  logic [7:0]  status_reg;
  logic [7:0]  irq_mask_reg;
  logic        wr_pending_reg;
  logic [7:0]  wr_addr_reg;
  logic [7:0]  gated;
  logic [7:0]  status_next;
  logic        wr_now;

  assign ev.kind  = can_irq_pkg::err_kind_t'(err_kind);
  assign ev.tx_ok = tx_frame_ok;
  assign ev.rx_ok = rx_frame_ok;

  can_err_counter counter_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ev      (ev)
  );

  // source gating; bit 3 handled the same way as the others
  always_comb begin
    gated = src_req & can_interrupt_mask_reg[7:0];
    gated[`BIT_RX_AFULL] = src_req[`BIT_RX_AFULL]
                           & can_interrupt_mask_reg[`BIT_RX_AFULL];
    gated[4] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 8'h00;
    end else begin
      irq_req <= gated;
    end
  end

  // address phase captured, write done in the data phase; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg    <= 8'h00;
    end else if (hready) begin
      wr_pending_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg    <= haddr[7:0];
    end
  end

  assign wr_now = wr_pending_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_interrupt_mask_reg <= `MASK_RESET;
    end else if (wr_now && wr_addr_reg == `OFS_MASK) begin
      can_interrupt_mask_reg <= hwdata[15:0] & `MASK_IMPL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= 8'h00;
    end else if (wr_now && wr_addr_reg == `OFS_IRQ_MASK) begin
      irq_mask_reg <= hwdata[7:0] & 8'(`MASK_IMPL);
    end
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (wr_now && wr_addr_reg == `OFS_STATUS) begin
      status_next = status_reg & ~hwdata[7:0];
    end
    status_next = status_next | gated;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & irq_mask_reg);
    end
  end

  // read data registered at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `OFS_MASK:       hrdata <= {16'h0000, can_interrupt_mask_reg};
        `OFS_ERR_COUNTS: hrdata <= {16'h0000, ev.tx_count, ev.rx_count};
        `OFS_STATUS:     hrdata <= {24'h000000, status_next};
        `OFS_IRQ_MASK:   hrdata <= {24'h000000, irq_mask_reg};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // error count offset has no write path at all

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: can_node_model.sv
/*
 holds a model of the other CAN nodes: it raises error and frame-done events
 assumes the block samples the events on rising hclk edges
*/
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  input  wire logic       hclk,
  output logic      [1:0] err_kind,
  output logic            tx_frame_ok,
  output logic            rx_frame_ok
);
  initial {err_kind, tx_frame_ok, rx_frame_ok} = 4'h0;
  // one cycle wide, so each call counts once
  task automatic pulse(input logic [1:0] k, input logic t, input logic r);
    @(posedge hclk) {err_kind, tx_frame_ok, rx_frame_ok} <= {k, t, r};
    @(posedge hclk) {err_kind, tx_frame_ok, rx_frame_ok} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// File: can_irq_error_count_properties.sv
/*
 holds the port checker of the mask and error count block
 assumes zero-wait AHB-Lite slave on hclk, bound to the top module
*/
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defs.svh"
module can_irq_error_count_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  src_req,
  input wire logic [1:0]  err_kind,
  input wire logic [7:0]  irq_req
);
  logic        ph;
  logic        wr;
  logic        no_ev;
  logic [7:0]  adr;
  logic [15:0] shadow;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) {ph, wr, adr} <= 10'h000;
    else {ph, wr, adr} <= {hsel & htrans[1] & hready, hwrite, haddr[7:0]};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) shadow <= `MASK_RESET;
    else if (ph && wr && adr == `OFS_MASK) shadow <= hwdata[15:0] & `MASK_IMPL;
  end
  // conservative: any error event voids the zero expectation; frame-done events do not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) no_ev <= 1'b1;
    else if (err_kind != 2'h0) no_ev <= 1'b0;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_req_gate: assert property (irq_req == ($past(src_req) & $past(shadow[7:0])))
    else $error("irq_req differs from gated sources");
  chk_afull_off: assert property (!shadow[3] |=> !irq_req[3])
    else $error("almost-full request passed while disabled");
  // read data is loaded before a same-edge write lands, hence the past value
  chk_mask_read: assert property (ph && !wr && adr == `OFS_MASK |-> hrdata == {16'h0000, $past(shadow)})
    else $error("mask read value wrong");
  chk_cnt_high: assert property (ph && !wr && adr == `OFS_ERR_COUNTS |-> hrdata[31:16] == 16'h0000)
    else $error("error count upper bits not zero");
  chk_cnt_reset: assert property (ph && !wr && adr == `OFS_ERR_COUNTS && no_ev |-> hrdata == 32'h0)
    else $error("counts not zero after reset");
  chk_unmapped_zero: assert property (ph && !wr && adr > `OFS_IRQ_MASK |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or erred");
  cover property (ph && !wr && adr == `OFS_ERR_COUNTS && !no_ev);
  cover property (irq_req[3]);
  cover property (ph && wr && adr == `OFS_MASK);
endmodule
bind can_irq_error_count can_irq_error_count_properties i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .src_req, .err_kind, .irq_req);
`default_nettype wire

// File: can_irq_error_count_tb.sv
/*
 holds the self-checking bench of the mask and error count block
 assumes the node model drives protocol events and the bench is bus master
*/
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defs.svh"
module can_irq_error_count_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  src_req = 8'h00;
  wire logic [31:0] hrdata;
  wire logic [7:0]  irq_req;
  wire logic [1:0]  err_kind;
  wire logic        hreadyout, hresp, irq, tx_ok, rx_ok;
  int mismatches = 0, num_checks = 0;
  always #2.5 hclk = ~hclk;
  can_irq_error_count i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_req, .err_kind,
    .tx_frame_ok(tx_ok), .rx_frame_ok(rx_ok), .irq_req, .irq);
  can_node_model i_node (.hclk, .err_kind, .tx_frame_ok(tx_ok), .rx_frame_ok(rx_ok));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after an edge; the slave may stretch either phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
  initial begin
    tick(4);
    hresetn <= 1'b1;
    xfer(0, `OFS_MASK, 0); chk(rd, 32'h0);
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'h0);
    xfer(1, `OFS_MASK, 32'hFFFF_FFFF); xfer(0, `OFS_MASK, 0); chk(rd, 32'h0000_00EF);
    xfer(1, `OFS_IRQ_MASK, 32'h1);
    src_req <= 8'h01; tick(1); src_req <= 8'h00; tick(3);
    chk({31'h0, irq}, 32'h1);
    xfer(1, `OFS_IRQ_MASK, 32'h0); tick(2); chk({31'h0, irq}, 32'h0);
    xfer(1, `OFS_IRQ_MASK, 32'h1); tick(2); chk({31'h0, irq}, 32'h1);
    xfer(1, `OFS_STATUS, 32'h1); tick(2); chk({31'h0, irq}, 32'h0);
    xfer(0, 8'h10, 0); chk(rd, 32'h0);
    src_req <= 8'hFF; tick(2); chk({24'h0, irq_req}, 32'hEF);
    xfer(1, `OFS_MASK, 32'hF7); tick(2); chk({24'h0, irq_req}, 32'hE7);
    xfer(1, `OFS_MASK, 32'h08); tick(2); chk({24'h0, irq_req}, 32'h08);
    xfer(0, `OFS_STATUS, 0); chk(rd, 32'h0000_00EF);
    xfer(1, `OFS_ERR_COUNTS, 32'hFFFF); xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'h0);
    repeat (3) i_node.pulse(2'h1, 1'b0, 1'b0);
    repeat (2) i_node.pulse(2'h2, 1'b0, 1'b0);
    i_node.pulse(2'h3, 1'b0, 1'b0);
    i_node.pulse(2'h0, 1'b1, 1'b1);
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'h1709);
    // frame-done in the same cycle as an error must lose
    i_node.pulse(2'h1, 1'b1, 1'b0);
    i_node.pulse(2'h2, 1'b0, 1'b1);
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'h1F0A);
    repeat (30) i_node.pulse(2'h1, 1'b0, 1'b0);
    repeat (15) i_node.pulse(2'h3, 1'b0, 1'b0);
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'hFF82);
    i_node.pulse(2'h0, 1'b1, 1'b1);
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'hFE77);
    hresetn <= 1'b0; tick(2); hresetn <= 1'b1;
    xfer(0, `OFS_ERR_COUNTS, 0); chk(rd, 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
